// >>> src/gat_alarm.v
`include "gat_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module gat_alarm #(
   parameter W      = 16,
   parameter CLK_HZ = 10000000,
   parameter TICK_N = CLK_HZ * `GAT_TICK_S
) (
   input  wire          clk_i,
   input  wire          rst_i,
   // classic wishbone slave
   input  wire          cyc_i,
   input  wire          stb_i,
   input  wire          we_i,
   input  wire [7:0]    adr_i,
   input  wire [3:0]    sel_i,
   input  wire [31:0]   dat_i,
   output wire [31:0]   dat_o,
   output wire          ack_o,
   // keypad, one-cycle pulses and the password flag
   input  wire          up_key_i,
   input  wire          down_key_i,
   input  wire          menu_advance_key_i,
   input  wire          reset_key_i,
   input  wire          pw_ok_i,
   // process inputs
   input  wire [W-1:0]  meas_i,
   input  wire          fault_i,
   // outputs
   output wire          alarm1_o,
   output wire          alarm2_o,
   output wire          relay1_o,
   output wire          relay2_o,
   output wire          fault_relay_o
);
   localparam DW = 6;
   localparam [3:0] S_IDLE = 4'h0;
   localparam [3:0] S_L1   = 4'h1;
   localparam [3:0] S_RST  = 4'h2;
   localparam [3:0] S_ARLY = 4'h3;
   localparam [3:0] S_FRLY = 4'h4;
   localparam [3:0] S_DIR  = 4'h5;
   localparam [3:0] S_LVL  = 4'h6;
   localparam [3:0] S_DB   = 4'h7;
   localparam [3:0] S_RCTL = 4'h8;
   localparam [3:0] S_DLY  = 4'h9;
   localparam [31:0] TICK_LAST = TICK_N - 1;

   reg  [3:0]          state_q;
   reg                 ch_q;
   reg  [1:0]          item_q;
   reg  [W-1:0]        edit_q;
   reg  [`GAT_CFG_W-1:0] cfg_q;
   reg  [2*W-1:0]      lvl_q;
   reg  [2*W-1:0]      db_q;
   reg  [2*DW-1:0]     dly_q;
   reg  [31:0]         tick_cnt_q;
   reg                 tick_q;
   reg                 ack_q;
   reg  [31:0]         rdat_q;
   reg  [31:0]         rdat_d;
   wire [1:0]          alarm;
   wire [1:0]          relay_act;
   wire                req;
   wire                wr;
   wire                key;
   wire [W-1:0]        cur_lvl;
   wire [W-1:0]        cur_db;
   wire [DW-1:0]       cur_dly;
   wire [31:0]         cfg_w;
   wire [31:0]         lvl1_w;
   wire [31:0]         lvl2_w;
   wire [31:0]         dly_w;
   wire [31:0]         cfg_m;
   wire [31:0]         dly_m;
   wire [31:0]         status_w;

   // byte-lane merge of a write into an old word
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  sel;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (sel[i]) begin
               merge[8*i +: 8] = nw[8*i +: 8];
            end
         end
      end
   endfunction

   // saturating step of a menu value
   function [W-1:0] step;
      input [W-1:0] v;
      input         up;
      input [W-1:0] max;
      begin
         if (up) begin
            step = (v >= max) ? max : v + {{(W-1){1'b0}}, 1'b1};
         end else begin
            step = (v == {W{1'b0}}) ? v : v - {{(W-1){1'b0}}, 1'b1};
         end
      end
   endfunction

   assign req = cyc_i && stb_i && !ack_q;
   // a write lands at the edge where the master sees ack high
   assign wr  = cyc_i && stb_i && we_i && ack_q;
   assign key = up_key_i || down_key_i;

   assign cur_lvl = ch_q ? lvl_q[W +: W] : lvl_q[0 +: W];
   assign cur_db  = ch_q ? db_q[W +: W] : db_q[0 +: W];
   assign cur_dly = ch_q ? dly_q[DW +: DW] : dly_q[0 +: DW];

   assign cfg_w  = {{(32-`GAT_CFG_W){1'b0}}, cfg_q};
   assign lvl1_w = {db_q[0 +: W], lvl_q[0 +: W]};
   assign lvl2_w = {db_q[W +: W], lvl_q[W +: W]};
   assign dly_w  = {16'h0000, 2'b00, dly_q[DW +: DW],
                    2'b00, dly_q[0 +: DW]};
   assign cfg_m  = merge(cfg_w, dat_i, sel_i);
   assign dly_m  = merge(dly_w, dat_i, sel_i);

   // seconds tick
   always @(posedge clk_i) begin
      if (rst_i) begin
         tick_cnt_q <= 32'h00000000;
         tick_q     <= 1'b0;
      end else if (tick_cnt_q >= TICK_LAST) begin
         tick_cnt_q <= 32'h00000000;
         tick_q     <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 32'h00000001;
         tick_q     <= 1'b0;
      end
   end

   // keypad menu; a bus write in the same cycle wins over the keypad
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= S_IDLE;
         ch_q    <= 1'b0;
         item_q  <= 2'h0;
         edit_q  <= {W{1'b0}};
         cfg_q   <= `GAT_CFG_RST;
         lvl_q   <= {`GAT_LVL2_RST, `GAT_LVL1_RST};
         db_q    <= {`GAT_DB_RST, `GAT_DB_RST};
         dly_q   <= {`GAT_DLY_RST, `GAT_DLY_RST};
      end else begin
         case (state_q)
         S_IDLE: begin
            if (menu_advance_key_i && pw_ok_i) begin
               state_q <= S_L1;
               item_q  <= 2'h0;
            end
         end
         S_L1: begin
            if (reset_key_i) begin
               state_q <= S_IDLE;
            end else if (up_key_i) begin
               item_q <= (item_q == `GAT_L1_LAST) ? 2'h0 : item_q + 2'h1;
            end else if (down_key_i) begin
               item_q <= (item_q == 2'h0) ? `GAT_L1_LAST : item_q - 2'h1;
            end else if (menu_advance_key_i
                         && item_q == `GAT_L1_ALARM) begin
               state_q <= S_RST;
               ch_q    <= 1'b0;
            end
         end
         S_RST: begin
            if (key) begin
               cfg_q[`GAT_CFG_MANUAL] <= !cfg_q[`GAT_CFG_MANUAL];
            end else if (menu_advance_key_i) begin
               state_q <= S_ARLY;
            end
         end
         S_ARLY: begin
            if (key) begin
               cfg_q[`GAT_CFG_ARLY_EN] <= !cfg_q[`GAT_CFG_ARLY_EN];
            end else if (menu_advance_key_i) begin
               state_q <= S_FRLY;
            end
         end
         S_FRLY: begin
            if (key) begin
               cfg_q[`GAT_CFG_FRLY_EN] <= !cfg_q[`GAT_CFG_FRLY_EN];
            end else if (menu_advance_key_i) begin
               state_q <= S_DIR;
            end
         end
         S_DIR: begin
            if (key && !ch_q) begin
               cfg_q[`GAT_CFG_DEC1] <= !cfg_q[`GAT_CFG_DEC1];
            end else if (key) begin
               cfg_q[`GAT_CFG_DEC2] <= !cfg_q[`GAT_CFG_DEC2];
            end else if (menu_advance_key_i) begin
               state_q <= S_LVL;
               edit_q  <= cur_lvl;
            end
         end
         S_LVL: begin
            if (key) begin
               edit_q <= step(edit_q, up_key_i, {W{1'b1}});
            end else if (menu_advance_key_i) begin
               lvl_q[ch_q*W +: W] <= edit_q;
               state_q <= S_DB;
               edit_q  <= cur_db;
            end
         end
         S_DB: begin
            if (key) begin
               edit_q <= step(edit_q, up_key_i, {W{1'b1}});
            end else if (menu_advance_key_i) begin
               db_q[ch_q*W +: W] <= edit_q;
               state_q <= S_RCTL;
            end
         end
         S_RCTL: begin
            if (key && !ch_q) begin
               cfg_q[`GAT_CFG_RCTL1] <= !cfg_q[`GAT_CFG_RCTL1];
            end else if (key) begin
               cfg_q[`GAT_CFG_RCTL2] <= !cfg_q[`GAT_CFG_RCTL2];
            end else if (menu_advance_key_i) begin
               state_q <= S_DLY;
               edit_q  <= {{(W-DW){1'b0}}, cur_dly};
            end
         end
         S_DLY: begin
            if (key) begin
               edit_q <= step(edit_q, up_key_i,
                              {{(W-DW){1'b0}}, `GAT_DLY_MAX});
            end else if (menu_advance_key_i) begin
               dly_q[ch_q*DW +: DW] <= edit_q[DW-1:0];
               if (!ch_q) begin
                  ch_q    <= 1'b1;
                  state_q <= S_DIR;
               end else begin
                  ch_q    <= 1'b0;
                  state_q <= S_L1;
                  item_q  <= `GAT_L1_ALARM;
               end
            end
         end
         default: begin
            state_q <= S_IDLE;
         end
         endcase

         // bus writes to settings
         if (wr) begin
            if (adr_i == `GAT_ADR_CFG) begin
               cfg_q <= cfg_m[`GAT_CFG_W-1:0];
            end else if (adr_i == `GAT_ADR_LVL1) begin
               {db_q[0 +: W], lvl_q[0 +: W]} <= merge(lvl1_w, dat_i, sel_i);
            end else if (adr_i == `GAT_ADR_LVL2) begin
               {db_q[W +: W], lvl_q[W +: W]} <= merge(lvl2_w, dat_i, sel_i);
            end else if (adr_i == `GAT_ADR_DLY) begin
               // each byte clamps on its own to the top of the range
               dly_q[0 +: DW] <= (dly_m[`GAT_DLY1_LO +: 8]
                                  > {2'b00, `GAT_DLY_MAX}) ? `GAT_DLY_MAX
                                 : dly_m[`GAT_DLY1_LO +: DW];
               dly_q[DW +: DW] <= (dly_m[`GAT_DLY2_LO +: 8]
                                   > {2'b00, `GAT_DLY_MAX}) ? `GAT_DLY_MAX
                                  : dly_m[`GAT_DLY2_LO +: DW];
            end
         end
      end
   end

   // two alarm channels
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : gen_ch
         gat_chan #(
            .W  (W),
            .DW (DW)
         ) u_chan (
            .clk_i       (clk_i),
            .rst_i       (rst_i),
            .tick_i      (tick_q),
            .meas_i      (meas_i),
            .lvl_i       (lvl_q[g*W +: W]),
            .db_i        (db_q[g*W +: W]),
            .dec_i       (g == 0 ? cfg_q[`GAT_CFG_DEC1]
                                 : cfg_q[`GAT_CFG_DEC2]),
            .dly_i       (dly_q[g*DW +: DW]),
            .manual_i    (cfg_q[`GAT_CFG_MANUAL]),
            .reset_key_i (reset_key_i && state_q == S_IDLE),
            .alarm_o     (alarm[g])
         );
      end
   endgenerate

   // relay drive: relay control gates the alarm, polarity sets the coil
   assign relay_act[0] = alarm[0] && cfg_q[`GAT_CFG_RCTL1];
   assign relay_act[1] = alarm[1] && cfg_q[`GAT_CFG_RCTL2];
   assign relay1_o = cfg_q[`GAT_CFG_ARLY_EN] ? relay_act[0]
                                             : !relay_act[0];
   assign relay2_o = cfg_q[`GAT_CFG_ARLY_EN] ? relay_act[1]
                                             : !relay_act[1];
   assign fault_relay_o = cfg_q[`GAT_CFG_FRLY_EN] ? fault_i
                                                  : !fault_i;
   assign alarm1_o = alarm[0];
   assign alarm2_o = alarm[1];

   assign status_w = {14'h0000, item_q, 4'h0, state_q, 1'b0, ch_q,
                      fault_relay_o, relay2_o, relay1_o, fault_i,
                      alarm[1], alarm[0]};

   // read mux
   always @* begin
      rdat_d = 32'h00000000;
      if (adr_i == `GAT_ADR_STATUS) begin
         rdat_d = status_w;
      end else if (adr_i == `GAT_ADR_CFG) begin
         rdat_d = cfg_w;
      end else if (adr_i == `GAT_ADR_LVL1) begin
         rdat_d = lvl1_w;
      end else if (adr_i == `GAT_ADR_LVL2) begin
         rdat_d = lvl2_w;
      end else if (adr_i == `GAT_ADR_DLY) begin
         rdat_d = dly_w;
      end
   end

   // one wait state: ack one edge after the request is seen
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h00000000;
      end else begin
         ack_q  <= req;
         rdat_q <= req ? rdat_d : 32'h00000000;
      end
   end

   assign ack_o = ack_q;
   assign dat_o = rdat_q;
endmodule

`default_nettype wire

// >>> src/gat_chan.v
`timescale 1ns/1ps
`default_nettype none

// one alarm channel: direction, deadband, hold-off delay, reset method
module gat_chan #(
   parameter W  = 16,
   parameter DW = 6
) (
   input  wire          clk_i,
   input  wire          rst_i,
   input  wire          tick_i,
   input  wire [W-1:0]  meas_i,
   input  wire [W-1:0]  lvl_i,
   input  wire [W-1:0]  db_i,
   input  wire          dec_i,
   input  wire [DW-1:0] dly_i,
   input  wire          manual_i,
   input  wire          reset_key_i,
   output wire          alarm_o
);
   wire signed [W+1:0] ms;
   wire signed [W+1:0] hi;
   wire signed [W+1:0] lo;
   wire                set_c;
   wire                clr_c;
   reg  [DW-1:0]       cnt_q;
   reg                 alarm_q;

   assign ms = {2'b00, meas_i};
   assign hi = {2'b00, lvl_i} + {2'b00, db_i};
   assign lo = {2'b00, lvl_i} - {2'b00, db_i};

   // increasing: set at level+band, clear below level-band
   // decreasing: mirrored
   assign set_c = dec_i ? (ms <= lo) : (ms >= hi);
   assign clr_c = dec_i ? (ms > hi) : (ms < lo);

   always @(posedge clk_i) begin
      if (rst_i) begin
         alarm_q <= 1'b0;
         cnt_q   <= {DW{1'b0}};
      end else if (!alarm_q) begin
         if (!set_c) begin
            cnt_q <= {DW{1'b0}};
         end else if (cnt_q >= dly_i) begin
            alarm_q <= 1'b1;
         end else if (tick_i) begin
            cnt_q <= cnt_q + {{(DW-1){1'b0}}, 1'b1};
         end
      end else if (manual_i ? (reset_key_i && !set_c) : clr_c) begin
         alarm_q <= 1'b0;
         cnt_q   <= {DW{1'b0}};
      end
   end

   assign alarm_o = alarm_q;
endmodule

`default_nettype wire

// >>> src/gat_defines.vh
`ifndef GAT_DEFINES_VH
`define GAT_DEFINES_VH

// register byte addresses
`define GAT_ADR_STATUS   8'h00
`define GAT_ADR_CFG      8'h04
`define GAT_ADR_LVL1     8'h08
`define GAT_ADR_LVL2     8'h0c
`define GAT_ADR_DLY      8'h10

// status fields
`define GAT_ST_ALM1      0
`define GAT_ST_ALM2      1
`define GAT_ST_FAULT     2
`define GAT_ST_RLY1      3
`define GAT_ST_RLY2      4
`define GAT_ST_FRLY      5
`define GAT_ST_CH        6
`define GAT_ST_MENU_LO   8
`define GAT_ST_MENU_HI   11
`define GAT_ST_ITEM_LO   16
`define GAT_ST_ITEM_HI   17

// configuration fields
`define GAT_CFG_MANUAL   0
`define GAT_CFG_ARLY_EN  1
`define GAT_CFG_FRLY_EN  2
`define GAT_CFG_DEC1     3
`define GAT_CFG_RCTL1    4
`define GAT_CFG_DEC2     5
`define GAT_CFG_RCTL2    6
`define GAT_CFG_W        7
`define GAT_CFG_RST      7'h50

// level register: level low half, deadband high half
`define GAT_LVL_LO       0
`define GAT_DB_LO        16
// delay register: channel one low byte, channel two next byte
`define GAT_DLY1_LO      0
`define GAT_DLY2_LO      8

// reset values of the settings
`define GAT_LVL1_RST     16'h0014
`define GAT_LVL2_RST     16'h0028
`define GAT_DB_RST       16'h0000
`define GAT_DLY_RST      6'h01

// delay range in seconds
`define GAT_DLY_MAX      6'h3c

// first-level menu last entry index and the alarm entry
`define GAT_L1_LAST      2'h3
`define GAT_L1_ALARM     2'h2

// seconds tick: period in seconds
`define GAT_TICK_S       1

`endif

// >>> tb/gat_alarm_monitor.sv
`include "gat_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module gat_monitor (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [31:0] dat_o,
   input  wire logic        ack_o,
   input  wire logic        up_key_i,
   input  wire logic        down_key_i,
   input  wire logic        fault_i,
   input  wire logic        alarm1_o,
   input  wire logic        alarm2_o,
   input  wire logic        relay1_o,
   input  wire logic        relay2_o,
   input  wire logic        fault_relay_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // outside reset, configuration bits can only move after a bus cycle or an up/down key
   wire       touch = cyc_i | up_key_i | down_key_i;
   wire [5:0] st    = {fault_relay_o, relay2_o, relay1_o,
                       fault_i, alarm2_o, alarm1_o};

   ack_after_req_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("no ack one cycle after request");
   ack_one_cycle_a: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   idle_data_zero_a: assert property (!ack_o |-> dat_o == 32'h0)
      else $error("read data outside ack");
   reset_clear_a: assert property (disable iff (1'b0)
      rst_i |=> !alarm1_o && !alarm2_o && !ack_o)
      else $error("reset left outputs active");
   status_read_a: assert property (ack_o && $past(stb_i) && !$past(we_i)
      && $past(adr_i) == `GAT_ADR_STATUS |-> dat_o[5:0] == $past(st))
      else $error("status read differs from pins");
   unmapped_zero_a: assert property (ack_o && !$past(we_i)
      && $past(adr_i) == 8'h20 |-> dat_o == 32'h0)
      else $error("unmapped read not zero");
   fault_follow_a: assert property ($changed(fault_i) && !$past(touch)
      && !$past(rst_i) |-> $changed(fault_relay_o))
      else $error("fault relay did not follow fault");
   relay1_cause_a: assert property ($changed(relay1_o) |->
      $changed(alarm1_o) || $past(touch) || $past(rst_i))
      else $error("relay one moved without cause");
   relay2_cause_a: assert property ($changed(relay2_o) |->
      $changed(alarm2_o) || $past(touch) || $past(rst_i))
      else $error("relay two moved without cause");
   relays_idle_a: assert property (!alarm1_o && !alarm2_o |->
      relay1_o == relay2_o)
      else $error("idle relays differ");

   cover property ($rose(alarm1_o));
   cover property ($fell(alarm2_o));
   cover property ($changed(fault_relay_o));
endmodule

bind gat_alarm gat_monitor i_gat_monitor (.clk_i, .rst_i, .cyc_i, .stb_i,
   .we_i, .adr_i, .dat_o, .ack_o, .up_key_i, .down_key_i, .fault_i,
   .alarm1_o, .alarm2_o, .relay1_o, .relay2_o, .fault_relay_o);

`default_nettype wire

// >>> tb/gat_keypad.sv
`timescale 1ns/1ps
`default_nettype none

// operator keypad: debounced one-cycle key pulses and the password flag
module gat_keypad (
   input  wire logic clk_i,
   output logic      up_key_o,
   output logic      down_key_o,
   output logic      adv_key_o,
   output logic      reset_key_o,
   output logic      pw_ok_o
);
   logic [3:0] k_q = 4'h0;

   assign {reset_key_o, adv_key_o, down_key_o, up_key_o} = k_q;
   initial pw_ok_o = 1'b0;

   // key 0 up, 1 down, 2 advance, 3 reset; one idle cycle between presses
   task automatic press(input int k, input int n);
      repeat (n) begin
         @(posedge clk_i);
         k_q <= 4'h1 << k;
         @(posedge clk_i);
         k_q <= 4'h0;
      end
   endtask
endmodule

`default_nettype wire

// >>> tb/tb_gas_alarm_threshold_logic.sv
`include "gat_defines.vh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
   $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module tb_gas_alarm_threshold_logic;
   logic        clk_i   = 1'b0;
   logic        rst_i   = 1'b1;
   logic        cyc_i   = 1'b0;
   logic        stb_i   = 1'b0;
   logic        we_i    = 1'b0;
   logic [7:0]  adr_i   = 8'h00;
   logic [31:0] dat_i   = 32'h0;
   logic [15:0] meas_i  = 16'h0;
   logic        fault_i = 1'b0;
   wire  [31:0] dat_o;
   wire         ack_o, up_k, dn_k, adv_k, rst_k, pw_ok;
   wire         alarm1_o, alarm2_o, relay1_o, relay2_o, fault_relay_o;
   logic [31:0] rd;
   logic [1:0]  ex [4] = '{2'b00, 2'b11, 2'b01, 2'b00};
   logic [15:0] mv [4] = '{16'd48, 16'd47, 16'd53, 16'd54};
   int          num_errors = 0;
   int          tests_run  = 0;
   int          cycles     = 0;

   gat_alarm #(.TICK_N(10)) i_gat_alarm (.clk_i, .rst_i, .cyc_i, .stb_i,
      .we_i, .adr_i, .sel_i(4'hf), .dat_i, .dat_o, .ack_o,
      .up_key_i(up_k), .down_key_i(dn_k), .menu_advance_key_i(adv_k),
      .reset_key_i(rst_k), .pw_ok_i(pw_ok), .meas_i, .fault_i,
      .alarm1_o, .alarm2_o, .relay1_o, .relay2_o, .fault_relay_o);
   gat_keypad i_gat_keypad (.clk_i, .up_key_o(up_k), .down_key_o(dn_k),
      .adv_key_o(adv_k), .reset_key_o(rst_k), .pw_ok_o(pw_ok));

   initial forever #50 clk_i = ~clk_i;

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         report_and_stop();
      end
   end

   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic kp(input int k, input int n);
      i_gat_keypad.press(k, n);
   endtask
   // single classic cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      @(posedge clk_i);
      {cyc_i, stb_i, we_i} <= {2'b11, w};
      adr_i <= a;
      dat_i <= d;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rd = dat_o;
      {cyc_i, stb_i, we_i} <= 3'b000;
   endtask

   task automatic t_regs();
      wb(0, `GAT_ADR_CFG, 0);
      `CHK(rd[6:0], `GAT_CFG_RST)
      wb(0, `GAT_ADR_LVL1, 0);
      `CHK(rd, {`GAT_DB_RST, `GAT_LVL1_RST})
      wb(0, `GAT_ADR_LVL2, 0);
      `CHK(rd, {`GAT_DB_RST, `GAT_LVL2_RST})
      wb(0, 8'h20, 0);
      `CHK(rd, 32'h0)
      `CHK({relay1_o, relay2_o, fault_relay_o}, 3'b111)
      wb(1, `GAT_ADR_DLY, 32'h4040);
      wb(0, `GAT_ADR_DLY, 0);
      `CHK({rd[13:8], rd[5:0]}, {2{`GAT_DLY_MAX}})
      wb(1, `GAT_ADR_DLY, 32'h0101);
      $display("t_regs done");
   endtask

   task automatic t_menu();
      kp(2, 1);
      wb(0, `GAT_ADR_STATUS, 0);
      `CHK(rd[11:8], 4'h0)
      i_gat_keypad.pw_ok_o <= 1'b1;
      kp(2, 1);
      kp(0, 2);
      wb(0, `GAT_ADR_STATUS, 0);
      `CHK({rd[11:8], rd[17:16]}, {4'h1, `GAT_L1_ALARM})
      // manual, relay types, channel one direction, one key each
      for (int i = 0; i < 4; i++) begin
         kp(2, 1);
         kp(i % 2, 1);
      end
      wb(0, `GAT_ADR_CFG, 0);
      `CHK(rd[3:0], 4'hf)
      `CHK(fault_relay_o, fault_i)
      kp(2, 1);
      kp(0, 1);
      kp(2, 1);
      kp(0, 2);
      kp(2, 1);
      kp(0, 1);
      kp(2, 1);
      kp(1, 3);
      kp(2, 1);
      wb(0, `GAT_ADR_STATUS, 0);
      `CHK({rd[11:8], rd[6]}, 5'h0b)
      wb(0, `GAT_ADR_LVL1, 0);
      `CHK(rd, 32'h0002_0015)
      wb(0, `GAT_ADR_DLY, 0);
      `CHK(rd[5:0], 6'h00)
      kp(0, 1);
      kp(2, 1);
      kp(1, 1);
      kp(2, 3);
      kp(0, 70);
      kp(2, 1);
      wb(0, `GAT_ADR_STATUS, 0);
      `CHK({rd[11:8], rd[17:16]}, {4'h1, `GAT_L1_ALARM})
      wb(0, `GAT_ADR_LVL2, 0);
      `CHK(rd, 32'h0000_0027)
      wb(0, `GAT_ADR_DLY, 0);
      `CHK(rd[13:8], `GAT_DLY_MAX)
      wb(0, `GAT_ADR_CFG, 0);
      `CHK(rd[6:4], 3'b110)
      kp(3, 1);
      i_gat_keypad.pw_ok_o <= 1'b0;
      $display("t_menu done");
   endtask

   task automatic t_inc();
      wb(1, `GAT_ADR_CFG, 32'h50);
      wb(1, `GAT_ADR_LVL1, {16'd5, 16'd100});
      wb(1, `GAT_ADR_DLY, 0);
      meas_i <= 16'd104;
      wt(4);
      `CHK(alarm1_o, 1'b0)
      meas_i <= 16'd105;
      wt(4);
      `CHK({alarm1_o, relay1_o}, 2'b10)
      meas_i <= 16'd95;
      wt(4);
      `CHK(alarm1_o, 1'b1)
      meas_i <= 16'd94;
      wt(4);
      `CHK(alarm1_o, 1'b0)
      wb(1, `GAT_ADR_LVL1, 32'd100);
      meas_i <= 16'd100;
      wt(4);
      `CHK(alarm1_o, 1'b1)
      $display("t_inc done");
   endtask

   task automatic t_dec();
      wb(1, `GAT_ADR_CFG, 32'h78);
      wb(1, `GAT_ADR_LVL1, 32'd47);
      wb(1, `GAT_ADR_LVL2, {16'd3, 16'd50});
      for (int i = 0; i < 4; i++) begin
         meas_i <= mv[i];
         wt(4);
         `CHK({alarm1_o, alarm2_o}, ex[i])
      end
      $display("t_dec done");
   endtask

   task automatic t_delay();
      int n;
      wb(1, `GAT_ADR_CFG, 32'h50);
      wb(1, `GAT_ADR_LVL1, 32'd100);
      wb(1, `GAT_ADR_DLY, 32'h0202);
      meas_i <= 16'd100;
      wt(9);
      `CHK(alarm1_o, 1'b0)
      n = 0;
      while (alarm1_o !== 1'b1 && n < 15) begin
         wt(1);
         n++;
      end
      `CHK(alarm1_o, 1'b1)
      $display("t_delay done");
   endtask

   task automatic t_manual();
      wb(1, `GAT_ADR_CFG, 32'h13);
      wb(1, `GAT_ADR_LVL2, 32'd40);
      wb(1, `GAT_ADR_DLY, 0);
      wt(1);
      meas_i <= 16'd40;
      fault_i <= 1'b1;
      wt(4);
      `CHK({alarm2_o, relay2_o, fault_relay_o}, 3'b100)
      meas_i <= 16'd0;
      wt(4);
      `CHK(alarm2_o, 1'b1)
      kp(3, 1);
      wt(2);
      `CHK(alarm2_o, 1'b0)
      $display("t_manual done");
   endtask

   initial begin
      wt(10);
      rst_i <= 1'b0;
      t_regs();
      t_menu();
      t_inc();
      t_dec();
      t_delay();
      t_manual();
      report_and_stop();
   end
endmodule

`default_nettype wire
